// ===== rtl/indirect_table_access_wake.sv
// ============================================================
// Indirect table access and wake-event registers
// ============================================================
// Purpose: Indirect VLAN and dynamic MAC table access plus wake-event registers
// Assumes: Register port and switch core share MCLK
// Notes:   Read data appears on REG_RDATA one cycle after REG_RD
//
// What this block does
// RULE1 - Selection 0x14 chooses VLAN table read
// RULE2 - Selection 0x04 chooses VLAN table write
// RULE3 - Writing address register triggers selected operation
// RULE4 - VID bits 11:2 set, 1:0 entry
// RULE5 - Entries at data bits 12:0,28:16,44:32,60:48
// RULE6 - Third entry spans registers 115 and 116
// RULE7 - Host read-modify-writes whole VLAN set
// RULE8 - Dynamic read index zero returns occupancy too
// RULE9 - Dynamic index from selection and address registers
// RULE10 - 72-bit entry across 112..120, MSB first
// RULE11 - Bit 71 flags empty table, resets high
// RULE12 - Bits 70:61 hold valid count minus one
// RULE13 - Bits 60:59 hold aging time stamp
// RULE14 - Bits 58:56 encode learning port
// RULE15 - Bit 55 high while entry not ready
// RULE16 - Bits 54:48 filter id, 47:0 MAC
// RULE17 - Space 100 selects wake registers, port field
// RULE18 - Wake control/status bytes at offsets 0..3
// RULE19 - Port mask bytes at offsets 4..7
// RULE20 - Global enable bit 1, polarity bit 0
// RULE21 - Status bits latch events, write one clears
// RULE22 - Pin asserts only for masked-in events
// RULE23 - Wake byte read: select, trigger, read 160
// RULE24 - Wake byte write: select, offset, write 160
// RULE25 - Entry: valid 12, members 11:7, id 6:0
// RULE26 - Set address 9:8 from selection bits 1:0
// RULE27 - Selection bit 4 chooses read or write
// RULE28 - Disabled pin stays at inactive level
`timescale 1ns/1ps
module indirect_table_access_wake
  import indirect_access_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  output logic             DYN_REQ,
  output logic      [9:0]  DYN_INDEX,
  input  wire logic        DYN_ACK,
  input  wire logic [10:0] DYN_COUNT,
  input  wire logic [1:0]  DYN_TSTAMP,
  input  wire logic [2:0]  DYN_SRC_PORT,
  input  wire logic [6:0]  DYN_FILTER_GROUP_ID,
  input  wire logic [47:0] DYN_MAC,
  input  wire logic [11:0] LOOKUP_VID,
  output logic             LOOKUP_VALID,
  output logic      [4:0]  LOOKUP_MEMBERS,
  output logic      [6:0]  LOOKUP_FILTER_GROUP_ID,
  input  wire logic [3:0]  MAGIC_EVT,
  input  wire logic [3:0]  LINK_EVT,
  input  wire logic [3:0]  ENERGY_EVT,
  output logic             WAKE_EVENT_OUTPUT
);

  // ============================================================
  // State
  // ============================================================
  typedef struct packed {
    state_t          st;          // Controller state
    logic [7:0]      ctrl0;       // Selection register
    logic [7:0]      ctrl1;       // Address register
    logic [71:0]     data;        // Data registers image
    logic [7:0]      wake_byte;   // Wake-event byte window
    logic [7:0]      rdata;       // Read data
    logic            dyn_req;     // Dynamic read request pulse
    logic [9:0]      dyn_index;   // Dynamic entry index
    logic [1:0]      glob;        // Global enable and polarity
    logic [3:0][2:0] status;      // Per-port magic, link, energy flags
    logic [3:0][2:0] mask;        // Per-port enables
  } core_t;

  core_t       s;                 // Current state
  core_t       next_s;            // Next state
  logic        vlan_we;           // VLAN set write strobe
  logic [9:0]  vlan_addr;         // VLAN set address
  logic [51:0] vlan_rdata;        // VLAN set read data
  logic [12:0] look_entry;        // Lookup result
  logic        pending;           // Any masked-in wake flag
  logic        is_read;           // Selection asks for a read
  logic [2:0]  space;             // Selected space
  logic [1:0]  table_sel;         // Selected table
  logic        trigger;           // Address register written
  logic        byte_wr;           // Wake byte register written

  // Read one wake-event byte for the selected port and offset
  function automatic logic [7:0] wake_read(input core_t c, input logic [7:0] off);
    logic [3:0] port;
    port      = c.ctrl0[3:0];
    wake_read = 8'h00;
    if (port == 4'h0 && off == OFF_CTRL_LSB) begin
      wake_read = {6'h00, c.glob};                                     // [RULE18]
    end else if (port >= 4'h1 && port <= 4'(WAKE_PORTS)) begin
      if (off == OFF_CTRL_LSB) begin
        wake_read = {5'h00, c.status[2'(port - 4'h1)]};                // [RULE18]
      end else if (off == OFF_MASK_LSB) begin
        wake_read = {5'h00, c.mask[2'(port - 4'h1)]};                  // [RULE19]
      end
    end
  endfunction

  // ============================================================
  // Selection decode
  // ============================================================
  assign is_read   = s.ctrl0[CTRL_READ_BIT];                           // [RULE27]
  assign space     = s.ctrl0[7:5];                                     // [RULE17]
  assign table_sel = s.ctrl0[3:2];
  assign trigger   = REG_WR && REG_ADDR == REG_CTRL1;                  // [RULE3]
  assign byte_wr   = REG_WR && REG_ADDR == REG_WAKE_BYTE;
  assign vlan_addr = {s.ctrl0[1:0], REG_WDATA};                        // [RULE26]
  assign vlan_we   = trigger && space == SPACE_TABLE && table_sel == TABLE_VLAN
                     && !is_read;                                      // [RULE2]

  // Any port with a flag that its mask lets through
  always_comb begin
    pending = 1'b0;
    for (int i = 0; i < WAKE_PORTS; i++) begin
      pending = pending | (|(s.status[i] & s.mask[i]));               // [RULE22]
    end
  end

  // ============================================================
  // Next-state logic
  // ============================================================
  always_comb begin
    logic [3:0] k;
    logic [3:0] port;
    k      = 4'(REG_ADDR - REG_DATA_FIRST);
    port   = s.ctrl0[3:0];
    next_s = s;
    next_s.dyn_req = 1'b0;

    // Host write to a plain register
    if (REG_WR) begin
      if (REG_ADDR == REG_CTRL0) begin
        next_s.ctrl0 = REG_WDATA;
      end else if (REG_ADDR == REG_CTRL1) begin
        next_s.ctrl1 = REG_WDATA;
      end else if (REG_ADDR >= REG_DATA_FIRST && REG_ADDR <= REG_DATA_LAST) begin
        // Byte k of the image, first register most significant
        next_s.data = (s.data & ~(72'h00_0000_0000_0000_00FF << byte_shift(k)))
                      | (72'(REG_WDATA) << byte_shift(k));             // [RULE10]
      end
    end

    // Wake flags: write one clears, a new event wins over the clear
    for (int i = 0; i < WAKE_PORTS; i++) begin
      if (byte_wr && space == SPACE_WAKE && !is_read && s.ctrl1 == OFF_CTRL_LSB
          && port == 4'(i + 1)) begin
        next_s.status[i] = s.status[i] & ~REG_WDATA[2:0];             // [RULE21]
      end
      next_s.status[i] = next_s.status[i]
                         | {MAGIC_EVT[i], LINK_EVT[i], ENERGY_EVT[i]}; // [RULE21]
    end

    // Wake byte window writes
    if (byte_wr) begin
      next_s.wake_byte = REG_WDATA;
      if (space == SPACE_WAKE && !is_read) begin                       // [RULE17]
        if (port == 4'h0 && s.ctrl1 == OFF_CTRL_LSB) begin
          next_s.glob = REG_WDATA[1:0];                                // [RULE20]
        end else if (port >= 4'h1 && port <= 4'(WAKE_PORTS) && s.ctrl1 == OFF_MASK_LSB) begin
          next_s.mask[2'(port - 4'h1)] = REG_WDATA[2:0];               // [RULE19]
        end
      end
    end

    // Trigger of a read operation
    if (trigger && is_read) begin
      if (space == SPACE_WAKE) begin
        next_s.wake_byte = wake_read(s, REG_WDATA);                    // [RULE18]
      end else if (space == SPACE_TABLE && table_sel == TABLE_VLAN) begin
        next_s.st = ST_VLAN_RD;                                        // [RULE1]
      end else if (space == SPACE_TABLE && table_sel == TABLE_DYN) begin
        next_s.dyn_req   = 1'b1;
        next_s.dyn_index = {s.ctrl0[1:0], REG_WDATA};                  // [RULE9]
        next_s.data[DYN_BUSY_BIT] = 1'b1;                              // [RULE15]
        next_s.st        = ST_DYN_WAIT;
      end
    end

    // Controller
    unique case (s.st)
      ST_IDLE: begin
      end
      ST_VLAN_RD: begin
        // Set read data arrives one cycle after the address
        next_s.data = vlan_to_data(vlan_rdata);                        // [RULE5] [RULE6]
        next_s.st   = ST_IDLE;
      end
      ST_DYN_WAIT: begin
        if (DYN_ACK) begin
          // An empty table reports a zero count beside the empty flag
          next_s.data = {DYN_COUNT == 11'h000,                         // [RULE11] [RULE8]
                         ((DYN_COUNT == 11'h000) ? 10'h000             // [RULE12]
                                                 : 10'(DYN_COUNT - 11'h001)),
                         DYN_TSTAMP,                                   // [RULE13]
                         DYN_SRC_PORT,                                 // [RULE14]
                         1'b0,                                         // [RULE15]
                         DYN_FILTER_GROUP_ID, DYN_MAC};                // [RULE16]
          next_s.st   = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // Host read data, unmapped offsets read zero
    if (REG_RD) begin
      if (REG_ADDR == REG_CTRL0) begin
        next_s.rdata = s.ctrl0;
      end else if (REG_ADDR == REG_CTRL1) begin
        next_s.rdata = s.ctrl1;
      end else if (REG_ADDR >= REG_DATA_FIRST && REG_ADDR <= REG_DATA_LAST) begin
        next_s.rdata = 8'(s.data >> byte_shift(k));                    // [RULE10]
      end else if (REG_ADDR == REG_WAKE_BYTE) begin
        next_s.rdata = s.wake_byte;
      end else begin
        next_s.rdata = 8'h00;
      end
    end
  end

  // State register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s           <= '0;
      s.st        <= ST_IDLE;
      s.ctrl0     <= CTRL_RESET;
      s.ctrl1     <= CTRL_RESET;
      s.data      <= DATA_RESET;                                       // [RULE11]
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // Submodules
  // ============================================================
  vlan_set_store u_store (
    .clk        (MCLK),
    .rst_n      (RESET_N),
    .host_we    (vlan_we),
    .host_addr  (vlan_addr),
    .host_wdata (data_to_vlan(s.data)),                                // [RULE5]
    .host_rdata (vlan_rdata),
    .look_vid   (LOOKUP_VID),
    .look_entry (look_entry)
  );

  wake_pin_drive u_pin (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .enable   (s.glob[1]),
    .polarity (s.glob[0]),
    .pending  (pending),
    .pin      (WAKE_EVENT_OUTPUT)
  );

  // Outputs
  assign REG_RDATA              = s.rdata;
  assign DYN_REQ                = s.dyn_req;
  assign DYN_INDEX              = s.dyn_index;
  assign LOOKUP_VALID           = look_entry[12];                      // [RULE25]
  assign LOOKUP_MEMBERS         = look_entry[11:7];                    // [RULE25]
  assign LOOKUP_FILTER_GROUP_ID = look_entry[6:0];                     // [RULE25]

  // ============================================================
  // Checks
  // ============================================================
  a_vlan_read_start: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RULE1]
    (trigger && s.ctrl0 == 8'h14) |=> s.st == ST_VLAN_RD ##1 s.st == ST_IDLE)
    else $error("VLAN read not started");
  a_vlan_write_strobe: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RULE2]
    vlan_we |-> (s.ctrl0[7:2] == 6'h01 && REG_WR && REG_ADDR == REG_CTRL1))
    else $error("VLAN write without selection");
  a_dyn_request: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RULE9]
    (trigger && s.ctrl0[7:2] == 6'h06) |=> DYN_REQ && DYN_INDEX == {$past(s.ctrl0[1:0]),
    $past(REG_WDATA)} ##1 !DYN_REQ) else $error("dynamic request wrong");
  a_dyn_not_ready: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RULE15]
    (s.st == ST_DYN_WAIT && !DYN_ACK) |=> s.data[DYN_BUSY_BIT])
    else $error("busy flag low while waiting");
  a_empty_flag: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RULE11]
    (s.st == ST_DYN_WAIT && DYN_ACK) |=> s.data[71] == ($past(DYN_COUNT) == 11'h000))
    else $error("empty flag wrong");
  a_count_field: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RULE12]
    (s.st == ST_DYN_WAIT && DYN_ACK)
    |=> s.data[70:61] == (($past(DYN_COUNT) == 11'h000) ? 10'h000
                          : 10'($past(DYN_COUNT) - 11'h001))) else $error("count wrong");
  a_flag_clear: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RULE21]
    (byte_wr && s.ctrl0 == 8'h81 && s.ctrl1 == OFF_CTRL_LSB && REG_WDATA[2]
     && !MAGIC_EVT[0]) |=> !s.status[0][2]) else $error("flag not cleared");
  a_flag_set_wins: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RULE21]
    LINK_EVT[1] |=> s.status[1][1]) else $error("event lost");
  c_vlan_read: cover property (@(posedge MCLK) disable iff (!RESET_N) s.st == ST_VLAN_RD);
  c_dyn_read: cover property (@(posedge MCLK) disable iff (!RESET_N)
    s.st == ST_DYN_WAIT && DYN_ACK);
  c_wake_write: cover property (@(posedge MCLK) disable iff (!RESET_N)
    byte_wr && space == SPACE_WAKE && !is_read);

endmodule

// ===== include/indirect_access_pkg.sv
// ============================================================
// Indirect table and wake-event access constants
// ============================================================
// Purpose: Offsets, codes, reset values and field helpers shared by the design
// Assumes: Byte-wide register port, one clock
// Notes:   Data registers hold a 72-bit image, first data register is the MSB
package indirect_access_pkg;

  // ============================================================
  // Register offsets on the byte register port
  // ============================================================
  localparam logic [7:0] REG_CTRL0      = 8'h6E;  // Selection register
  localparam logic [7:0] REG_CTRL1      = 8'h6F;  // Address and trigger register
  localparam logic [7:0] REG_DATA_FIRST = 8'h70;  // Data bits 71:64
  localparam logic [7:0] REG_DATA_LAST  = 8'h78;  // Data bits 7:0
  localparam logic [7:0] REG_WAKE_BYTE  = 8'hA0;  // Wake-event byte window

  // ============================================================
  // Selection register fields
  // ============================================================
  localparam int         CTRL_READ_BIT = 4;       // 1 = read, 0 = write
  localparam logic [2:0] SPACE_TABLE   = 3'h0;    // Bits 7:5 for tables
  localparam logic [2:0] SPACE_WAKE    = 3'h4;    // Bits 7:5 for wake-event space
  localparam logic [1:0] TABLE_VLAN    = 2'h1;    // Bits 3:2 for VLAN table
  localparam logic [1:0] TABLE_DYN     = 2'h2;    // Bits 3:2 for dynamic MAC table

  // ============================================================
  // Wake-event byte offsets and ports
  // ============================================================
  localparam logic [7:0] OFF_CTRL_LSB = 8'h03;    // Control/status bits 7:0
  localparam logic [7:0] OFF_MASK_LSB = 8'h07;    // Mask bits 7:0
  localparam int         WAKE_PORTS   = 4;        // Ports with wake registers

  // ============================================================
  // Dynamic entry fields and reset values
  // ============================================================
  localparam int          DYN_EMPTY_BIT = 71;     // Table empty flag
  localparam int          DYN_BUSY_BIT  = 55;     // Entry not ready flag
  localparam logic [71:0] DATA_RESET    = 72'h80_0000_0000_0000_0000;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // Controller states, Gray along idle -> read -> wait
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_VLAN_RD  = 2'b01,
    ST_DYN_WAIT = 2'b11
  } state_t;

  // Pick one 13-bit entry out of a packed four-entry set
  function automatic logic [12:0] vlan_lane(input logic [51:0] set, input logic [1:0] idx);
    vlan_lane = set[13*idx +: 13];
  endfunction

  // Spread a set over the data image, three spare bits between entries
  function automatic logic [71:0] vlan_to_data(input logic [51:0] set);
    vlan_to_data = {11'h000, set[51:39], 3'h0, set[38:26], 3'h0, set[25:13], 3'h0, set[12:0]};
  endfunction

  // Gather a set back from the data image
  function automatic logic [51:0] data_to_vlan(input logic [71:0] d);
    data_to_vlan = {d[60:48], d[44:32], d[28:16], d[12:0]};
  endfunction

  // Bit shift of data register k, k = 0 for the first data register
  function automatic int byte_shift(input logic [3:0] k);
    byte_shift = 8 * (8 - int'(k));
  endfunction

endpackage

// ===== rtl/vlan_set_store.sv
// ============================================================
// VLAN set memory
// ============================================================
// Purpose: 1024 sets of four 13-bit VLAN entries, host port and lookup port
// Assumes: Single clock, host read data valid one cycle after the address
// Notes:   Memory contents have no reset; software initialises the table
`timescale 1ns/1ps
module vlan_set_store
  import indirect_access_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        host_we,
  input  wire logic [9:0]  host_addr,
  input  wire logic [51:0] host_wdata,
  output logic      [51:0] host_rdata,
  input  wire logic [11:0] look_vid,
  output logic      [12:0] look_entry
);

  typedef struct packed {
    logic [51:0] host_rdata;   // Registered host read data
    logic [12:0] look_entry;   // Registered lookup entry
  } store_t;

  logic [51:0] mem [1024];     // Set storage
  store_t      s;              // Current state
  store_t      next_s;         // Next state

  // ============================================================
  // Read paths
  // ============================================================
  always_comb begin
    next_s            = s;
    next_s.host_rdata = mem[host_addr];
    // Set from VID 11:2, lane from VID 1:0
    next_s.look_entry = vlan_lane(mem[look_vid[11:2]], look_vid[1:0]); // [RULE4]
  end

  // Write port
  always_ff @(posedge clk) begin
    if (host_we) begin
      mem[host_addr] <= host_wdata;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign host_rdata = s.host_rdata;
  assign look_entry = s.look_entry;

endmodule

// ===== rtl/wake_pin_drive.sv
// ============================================================
// Wake-event pin driver
// ============================================================
// Purpose: Registered wake-event pin with enable and polarity
// Assumes: pending already holds status gated by masks
// Notes:   Pin shows the inactive level whenever it is disabled
`timescale 1ns/1ps
module wake_pin_drive (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic polarity,
  input  wire logic pending,
  output logic      pin
);

  typedef struct packed {
    logic pin;                 // Pin level
  } pin_t;

  pin_t s;                     // Current state
  pin_t next_s;                // Next state

  // Active level only when enabled and something is pending
  always_comb begin
    next_s     = s;
    next_s.pin = (enable && pending) ? polarity : !polarity; // [RULE20] [RULE28]
  end

  // State register, reset to the inactive level of active-low default
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{pin: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign pin = s.pin;

  a_pin_off_level: assert property (@(posedge clk) disable iff (!rst_n) // [RULE28]
    !enable |=> pin == !$past(polarity)) else $error("pin not inactive when disabled");
  a_pin_on_level: assert property (@(posedge clk) disable iff (!rst_n) // [RULE22]
    (enable && pending) |=> pin == $past(polarity)) else $error("pin not asserted");
  c_pin_asserted: cover property (@(posedge clk) disable iff (!rst_n) enable && pending);

endmodule

// ===== tb/dyn_core_model.sv
// Purpose: Switch core stand-in answering dynamic entry fetches
// Assumes: One fetch open at a time; entry fields derive from the index
// Notes:   Fields are only valid with ack; otherwise they show inverted junk, except port, which shows all ones
`timescale 1ns/1ps
module dyn_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic [9:0]  index,
  input  wire logic [3:0]  delay,
  output logic             ack,
  output logic      [10:0] count,
  output logic      [1:0]  tstamp,
  output logic      [2:0]  port,
  output logic      [6:0]  filter_group_id,
  output logic      [47:0] mac
);
  logic [4:0] wait_cnt;  // Cycles left before the answer
  // ============================================================
  // Answer each fetch after the programmed delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 5'h00;
      ack      <= 1'b0;
    end else begin
      ack      <= (wait_cnt == 5'h01);
      wait_cnt <= req ? {1'b0, delay} : (wait_cnt == 5'h00) ? 5'h00 : wait_cnt - 5'h01;
    end
  end
  // Occupancy and entry fields, index 0 means an empty table
  assign count  = ack ? {1'b0, index} : ~{1'b0, index};
  assign tstamp = ack ? index[1:0] : ~index[1:0];
  assign port   = ack ? {1'b0, index[1:0]} : 3'h7;
  assign filter_group_id    = ack ? index[6:0] : ~index[6:0];
  assign mac    = ack ? {4{index, 2'b01}} : ~{4{index, 2'b01}};
endmodule

// ===== tb/indirect_table_access_wake_tb.sv
// Purpose: Self-checking bench for the indirect table and wake block
// Assumes: Host strobes change on the falling edge, one idle cycle between
// Notes:   Dynamic entries come from the core stand-in
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module indirect_table_access_wake_tb
  import indirect_access_pkg::*;
();
  logic        MCLK, RESET_N, REG_WR, REG_RD, DYN_REQ, DYN_ACK, LOOKUP_VALID;
  logic        WAKE_EVENT_OUTPUT;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, v;
  logic [9:0]  DYN_INDEX, a;
  logic [10:0] DYN_COUNT;
  logic [1:0]  DYN_TSTAMP;
  logic [2:0]  DYN_SRC_PORT;
  logic [6:0]  DYN_FILTER_GROUP_ID, LOOKUP_FILTER_GROUP_ID;
  logic [47:0] DYN_MAC;
  logic [11:0] LOOKUP_VID, evts;
  logic [4:0]  LOOKUP_MEMBERS;
  logic [12:0] ent;
  logic [3:0]  dly;
  logic [71:0] img, ref_img;
  int          n_errors, samples_checked, t, p;
  integer      seed = 32'hf9e3;
  indirect_table_access_wake indirect_table_access_wake_inst (.MCLK, .RESET_N, .REG_WR,
    .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .DYN_REQ, .DYN_INDEX, .DYN_ACK, .DYN_COUNT,
    .DYN_TSTAMP, .DYN_SRC_PORT, .DYN_FILTER_GROUP_ID, .DYN_MAC, .LOOKUP_VID, .LOOKUP_VALID,
    .LOOKUP_MEMBERS, .LOOKUP_FILTER_GROUP_ID, .MAGIC_EVT(evts[11:8]), .LINK_EVT(evts[7:4]),
    .ENERGY_EVT(evts[3:0]), .WAKE_EVENT_OUTPUT);
  dyn_core_model dyn_core_model_inst (.clk(MCLK), .rst_n(RESET_N), .req(DYN_REQ),
    .index(DYN_INDEX), .delay(dly), .ack(DYN_ACK), .count(DYN_COUNT), .tstamp(DYN_TSTAMP),
    .port(DYN_SRC_PORT), .filter_group_id(DYN_FILTER_GROUP_ID), .mac(DYN_MAC));
  // ============================================================
  // Host register cycles, each starts and ends on a falling edge
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    REG_WR = 1'b1;
    REG_ADDR = ad;
    REG_WDATA = d;
    @(negedge MCLK) REG_WR = 1'b0;
    @(negedge MCLK);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    REG_RD = 1'b1;
    REG_ADDR = ad;
    @(negedge MCLK) REG_RD = 1'b0;
    @(negedge MCLK) d = REG_RDATA;
  endtask
  task automatic img_io(input bit w, inout logic [71:0] x);
    for (int k = 0; k < 9; k++) begin
      if (w) wr(8'(REG_DATA_FIRST + k), x[8*(8-k) +: 8]);
      else rd(8'(REG_DATA_FIRST + k), x[8*(8-k) +: 8]);
    end
  endtask
  // Selection then offset or address write, the second one triggers
  task automatic wake(input logic [7:0] c0, input logic [7:0] off, input bit w,
                      inout logic [7:0] d);
    wr(REG_CTRL0, c0);
    wr(REG_CTRL1, off);
    if (w) wr(REG_WAKE_BYTE, d);
    else rd(REG_WAKE_BYTE, d);
    repeat (2) @(negedge MCLK);
  endtask
  task automatic pulse(input int ty, input int pt);
    evts = 12'(1) << (4 * ty + pt - 1);
    @(negedge MCLK) evts = 12'h000;
    repeat (4) @(negedge MCLK);
  endtask
  function automatic logic [71:0] dyn_ref(input logic [9:0] i);
    dyn_ref = {i == 10'h000, (i == 10'h000) ? 10'h000 : i - 10'h001, i[1:0], 1'b0, i[1:0],
               1'b0, i[6:0], {4{i, 2'b01}}};
  endfunction
  task automatic test_done;
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  initial begin
    #250000;
    n_errors++;
    test_done();
  end
  // ============================================================
  // Main sequence: reset, VLAN sets, dynamic entries, wake events
  initial begin
    {RESET_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA, LOOKUP_VID, evts} = '0;
    dly = 4'h6;
    repeat (16) @(negedge MCLK);
    RESET_N = 1'b1;
    `CHK(WAKE_EVENT_OUTPUT, 1'b1)
    img_io(0, img);
    `CHK(img, DATA_RESET)
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : 10'($random(seed));
      ref_img = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      img_io(1, ref_img);
      wr(REG_CTRL0, {SPACE_TABLE, 1'b0, TABLE_VLAN, a[9:8]});
      wr(REG_CTRL1, a[7:0]);
      img = ~ref_img;
      img_io(1, img);
      wr(REG_CTRL0, {SPACE_TABLE, 1'b1, TABLE_VLAN, a[9:8]});
      wr(REG_CTRL1, a[7:0]);
      img_io(0, img);
      `CHK(img, ref_img & 72'h00_1FFF_1FFF_1FFF_1FFF)
      for (int e = 0; e < 4; e++) begin
        LOOKUP_VID = {a, 2'(e)};
        repeat (2) @(negedge MCLK);
        ent = {LOOKUP_VALID, LOOKUP_MEMBERS, LOOKUP_FILTER_GROUP_ID};
        `CHK(ent, img[16*e +: 13])
      end
    end
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 10'h000 : 10'($random(seed));
      wr(REG_CTRL0, {SPACE_TABLE, 1'b1, TABLE_DYN, a[9:8]});
      wr(REG_CTRL1, a[7:0]);
      rd(8'h72, v);
      `CHK(v[7], 1'b1)
      `CHK(DYN_INDEX, a)
      for (t = 0; t < 40 && DYN_ACK !== 1'b1; t++) @(negedge MCLK);
      @(negedge MCLK);
      img_io(0, img);
      `CHK(img, dyn_ref(a))
    end
    p = 1 + ($random(seed) & 32'h0000_0003);
    t = ($random(seed) & 32'h0000_00ff) % 3;
    v = 8'h01;
    wake(8'h80, 8'h03, 1, v);
    v = 8'h07;
    wake(8'h80 | 8'(p), 8'h07, 1, v);
    wake(8'h90 | 8'(p), 8'h07, 0, v);
    `CHK(v, 8'h07)
    pulse(t, p);
    `CHK(WAKE_EVENT_OUTPUT, 1'b0)
    wake(8'h90 | 8'(p), 8'h03, 0, v);
    `CHK(v, 8'(1 << t))
    wake(8'h90 | 8'(p), 8'h00, 0, v);
    `CHK(v, 8'h00)
    v = 8'h03;
    wake(8'h80, 8'h03, 1, v);
    `CHK(WAKE_EVENT_OUTPUT, 1'b1)
    v = 8'h02;
    wake(8'h80, 8'h03, 1, v);
    `CHK(WAKE_EVENT_OUTPUT, 1'b0)
    v = 8'(1 << t);
    wake(8'h80 | 8'(p), 8'h03, 1, v);
    `CHK(WAKE_EVENT_OUTPUT, 1'b1)
    v = 8'h00;
    wake(8'h80 | 8'(p), 8'h07, 1, v);
    pulse((t + 1) % 3, p);
    `CHK(WAKE_EVENT_OUTPUT, 1'b1)
    wake(8'h90 | 8'(p), 8'h03, 0, v);
    `CHK(v, 8'(1 << ((t + 1) % 3)))
    test_done();
  end
endmodule
